// File: include/oper_addr_pkg.sv
package oper_addr_pkg;
   // Addressing modes offered by the decode stage
   typedef enum logic [2:0] {
      MODE_DIRECT,
      MODE_SHORT,
      MODE_SPECIAL,
      MODE_REG,
      MODE_PAIR,
      MODE_INDIRECT,
      MODE_BASED,
      MODE_STACK
   } addr_mode_t;

   // Short direct window bounds
   localparam logic [15:0] SHORT_LOW = 16'hFE80;
   localparam logic [15:0] SHORT_HIGH = 16'hFF1F;
   localparam logic [15:0] RAM_HIGH = 16'hFEFF;
   localparam logic [15:0] SPECIAL_BASE = 16'hFF00;
   localparam logic [7:0] SHORT_SPECIAL_TOP = 8'h1F;
   localparam logic [6:0] SHORT_UPPER_BITS = 7'h7F;
   localparam logic [7:0] SPECIAL_PAGE = 8'hFF;
   // Internal high-speed RAM region reachable by the stack
   localparam logic [15:0] RAM_LOW = 16'hFE80;
   // Absolute numbers of register pairs
   localparam logic [1:0] PAIR_AX = 2'h0;
   localparam logic [1:0] PAIR_BC = 2'h1;
   localparam logic [1:0] PAIR_DE = 2'h2;
   localparam logic [1:0] PAIR_HL = 2'h3;
   // Reset values
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [2:0] REG_RESET = 3'h0;
endpackage : oper_addr_pkg

// File: src/operand_address_generator.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1: Direct mode uses 16-bit immediate address
// RULE2: Short direct maps into FE80H-FF1FH window; operands 20H-7FH land below it at FE20H-FE7FH
// RULE3: Window holds RAM then special registers
// RULE4: Operands 80H-FFH clear address bit eight
// RULE5: Operands 00H-1FH set address bit eight
// RULE6: Upper bits high, low bits from operand
// RULE7: Word short operands need even address
// RULE8: Special mode uses FF00H page plus immediate
// RULE9: Low 32 special bytes use short mode
// RULE10: Three-bit code picks one byte register
// RULE11: Four pairs and eight registers numbered
// RULE12: Indirect uses selected pair contents
// RULE13: Based adds zero-extended byte to pair
// RULE14: Based sum wraps, carry discarded
// RULE15: Stack pointer addresses stack operations
// RULE16: Stack accesses only internal high-speed RAM
module operand_address_generator
   import oper_addr_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   // Decode request
   input wire logic req_valid_in,
   input wire addr_mode_t mode_in,
   input wire logic word_op_in,
   input wire logic [15:0] imm16_in,
   input wire logic [7:0] imm8_in,
   input wire logic [2:0] reg_code_in,
   input wire logic [1:0] pair_code_in,
   // Register and stack pointer values
   input wire logic [15:0] pair_ax_in,
   input wire logic [15:0] pair_bc_in,
   input wire logic [15:0] pair_de_in,
   input wire logic [15:0] base_pointer_pair_in,
   input wire logic [15:0] stack_ptr_in,
   // Results
   output logic addr_valid_out,
   output logic [15:0] mem_addr_out,
   output logic mem_sel_out,
   output logic reg_sel_out,
   output logic [2:0] reg_num_out,
   output logic pair_sel_out,
   output logic [1:0] pair_num_out,
   output logic addr_error_out
);
   // Mapped short address from the leaf
   logic [15:0] short_addr;
   // Selected pair contents
   logic [15:0] pair_value;
   // Combinational address and flags
   logic [15:0] addr_d;
   logic mem_d;
   logic err_d;
   // Registered results
   logic valid_q;
   logic [15:0] addr_q;
   logic mem_q;
   logic reg_q;
   logic pair_q;
   logic [2:0] reg_num_q;
   logic [1:0] pair_num_q;
   logic err_q;

   // Short direct mapping lives in its own module for reuse
   short_map u_short (
      .operand_in(imm8_in),
      .address_out(short_addr)
   );

   // Pair selection by absolute number
   always_comb begin
      case (pair_code_in)
         PAIR_AX: pair_value = pair_ax_in; // RULE11 RULE12
         PAIR_BC: pair_value = pair_bc_in;
         PAIR_DE: pair_value = pair_de_in;
         PAIR_HL: pair_value = base_pointer_pair_in;
         default: pair_value = pair_ax_in;
      endcase
   end

   // Address formation per mode
   always_comb begin
      addr_d = ADDR_RESET;
      mem_d = 1'b1;
      err_d = 1'b0;
      case (mode_in)
         // Full reach of the memory space
         MODE_DIRECT: addr_d = imm16_in; // RULE1
         // Window into RAM and low special registers
         MODE_SHORT: begin
            addr_d = short_addr; // RULE2 RULE3 RULE9
            // Word operands must be even so both bytes stay inside
            if (word_op_in && imm8_in[0]) begin
               err_d = 1'b1; // RULE7
            end
         end
         // Whole special page
         MODE_SPECIAL: addr_d = {SPECIAL_PAGE, imm8_in}; // RULE8
         // Register targets carry no memory address
         MODE_REG: mem_d = 1'b0; // RULE10
         MODE_PAIR: mem_d = 1'b0; // RULE11
         MODE_INDIRECT: addr_d = pair_value; // RULE12
         // 16-bit sum; the carry simply falls off the top
         MODE_BASED: addr_d = 16'(base_pointer_pair_in + {8'h00, imm8_in}); // RULE13 RULE14
         MODE_STACK: begin
            addr_d = stack_ptr_in; // RULE15
            // Stack outside internal RAM is flagged, never silently used
            if (stack_ptr_in < RAM_LOW || stack_ptr_in > RAM_HIGH) begin
               err_d = 1'b1; // RULE16
            end
         end
         default: mem_d = 1'b0;
      endcase
   end

   // Result valid strobe
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         valid_q <= 1'b0;
      end else if (clk_en_in) begin
         valid_q <= req_valid_in;
      end
   end

   // Address and selection registers
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         addr_q <= ADDR_RESET;
         mem_q <= 1'b0;
         reg_q <= 1'b0;
         pair_q <= 1'b0;
         reg_num_q <= REG_RESET;
         pair_num_q <= PAIR_AX;
         err_q <= 1'b0;
      end else if (clk_en_in && req_valid_in) begin
         addr_q <= addr_d;
         mem_q <= mem_d && !err_d;
         reg_q <= (mode_in == MODE_REG); // RULE10
         pair_q <= (mode_in == MODE_PAIR); // RULE11
         reg_num_q <= reg_code_in; // RULE10
         pair_num_q <= pair_code_in; // RULE11
         err_q <= err_d;
      end
   end

   // Outputs come straight from the result registers, so all but the valid strobe hold between requests
   assign addr_valid_out = valid_q;
   assign mem_addr_out = addr_q;
   assign mem_sel_out = mem_q;
   assign reg_sel_out = reg_q;
   assign pair_sel_out = pair_q;
   assign reg_num_out = reg_num_q;
   assign pair_num_out = pair_num_q;
   assign addr_error_out = err_q;

   // Window operands always land inside the window; 20H..7FH fall below it by design
   AST_SHORT_WINDOW: assert property (@(posedge clk_in) disable iff (reset_in) // RULE2
      (clk_en_in && req_valid_in && mode_in == MODE_SHORT &&
      (imm8_in <= 8'h1F || imm8_in >= 8'h80)) |=>
      (mem_addr_out >= SHORT_LOW && mem_addr_out <= SHORT_HIGH))
      else $error("short address outside window");
   AST_SHORT_LOW_SPECIAL: assert property (@(posedge clk_in) disable iff (reset_in) // RULE5
      (clk_en_in && req_valid_in && mode_in == MODE_SHORT && imm8_in <= 8'h1F) |=>
      (mem_addr_out[8] && mem_addr_out >= SPECIAL_BASE))
      else $error("low short operand missed special area");
   AST_SHORT_RAM: assert property (@(posedge clk_in) disable iff (reset_in) // RULE4
      (clk_en_in && req_valid_in && mode_in == MODE_SHORT && imm8_in >= 8'h80) |=>
      (!mem_addr_out[8] && mem_addr_out <= RAM_HIGH))
      else $error("high short operand missed RAM");
   AST_DIRECT: assert property (@(posedge clk_in) disable iff (reset_in) // RULE1
      (clk_en_in && req_valid_in && mode_in == MODE_DIRECT) |=> (mem_addr_out == $past(imm16_in)))
      else $error("direct address mismatch");
   AST_SPECIAL: assert property (@(posedge clk_in) disable iff (reset_in) // RULE8
      (clk_en_in && req_valid_in && mode_in == MODE_SPECIAL) |=>
      (mem_addr_out == {8'hFF, $past(imm8_in)}))
      else $error("special address mismatch");
   AST_BASED: assert property (@(posedge clk_in) disable iff (reset_in) // RULE14
      (clk_en_in && req_valid_in && mode_in == MODE_BASED) |=>
      (mem_addr_out == 16'($past(base_pointer_pair_in) + 16'($past(imm8_in)))))
      else $error("based sum mismatch");
   AST_ODD_WORD: assert property (@(posedge clk_in) disable iff (reset_in) // RULE7
      (clk_en_in && req_valid_in && mode_in == MODE_SHORT && word_op_in && imm8_in[0]) |=>
      (addr_error_out && !mem_sel_out))
      else $error("odd word short address accepted");
   // Stack results either sit in internal RAM or are flagged and withheld
   AST_STACK_RAM: assert property (@(posedge clk_in) disable iff (reset_in) // RULE16
      (clk_en_in && req_valid_in && mode_in == MODE_STACK) |=>
      ((mem_sel_out && !addr_error_out && mem_addr_out >= RAM_LOW && mem_addr_out <= RAM_HIGH) ||
       (addr_error_out && !mem_sel_out)))
      else $error("stack access outside RAM");
   AST_REG_NUM: assert property (@(posedge clk_in) disable iff (reset_in) // RULE10
      (clk_en_in && req_valid_in && mode_in == MODE_REG) |=>
      (reg_sel_out && !mem_sel_out && reg_num_out == $past(reg_code_in)))
      else $error("register selection mismatch");

   // Low short operands stay in the special register half of the window
   AST_SHORT_SPECIAL_HALF: assert property (@(posedge clk_in) disable iff (reset_in) // RULE3
      (clk_en_in && req_valid_in && mode_in == MODE_SHORT && imm8_in <= 8'h1F) |=>
      (mem_addr_out >= SPECIAL_BASE && mem_addr_out <= SHORT_HIGH))
      else $error("low short operand outside special half");

   // High short operands stay in the internal RAM half of the window
   AST_SHORT_RAM_HALF: assert property (@(posedge clk_in) disable iff (reset_in) // RULE3
      (clk_en_in && req_valid_in && mode_in == MODE_SHORT && imm8_in >= 8'h80) |=>
      (mem_addr_out >= SHORT_LOW && mem_addr_out <= RAM_HIGH))
      else $error("high short operand outside RAM half");

   // Upper seven bits are all ones, low byte is the operand itself
   AST_SHORT_FIELDS: assert property (@(posedge clk_in) disable iff (reset_in) // RULE6
      (clk_en_in && req_valid_in && mode_in == MODE_SHORT) |=>
      (mem_addr_out[15:9] == SHORT_UPPER_BITS && mem_addr_out[7:0] == $past(imm8_in)))
      else $error("short address fields mismatch");

   // Operands 20H..7FH also clear bit eight; they land below the window
   AST_SHORT_MID: assert property (@(posedge clk_in) disable iff (reset_in) // RULE4
      (clk_en_in && req_valid_in && mode_in == MODE_SHORT && imm8_in >= 8'h20 && imm8_in < 8'h80)
      |=> (!mem_addr_out[8]))
      else $error("mid short operand set bit eight");

   // Lowest 32 special registers are reached through the short mode
   AST_SHORT_LOW_PAGE: assert property (@(posedge clk_in) disable iff (reset_in) // RULE9
      (clk_en_in && req_valid_in && mode_in == MODE_SHORT && imm8_in <= 8'h1F) |=>
      (mem_addr_out == SPECIAL_BASE + 16'($past(imm8_in))))
      else $error("low special register not reached by short mode");

   // Special mode always selects memory inside the top page
   AST_SPECIAL_PAGE: assert property (@(posedge clk_in) disable iff (reset_in) // RULE8
      (clk_en_in && req_valid_in && mode_in == MODE_SPECIAL) |=>
      (mem_sel_out && !addr_error_out && mem_addr_out >= SPECIAL_BASE))
      else $error("special access outside top page");

   // Pair mode names the pair by its absolute number, no memory access
   AST_PAIR_NUM: assert property (@(posedge clk_in) disable iff (reset_in) // RULE11
      (clk_en_in && req_valid_in && mode_in == MODE_PAIR) |=>
      (pair_sel_out && !reg_sel_out && !mem_sel_out && pair_num_out == $past(pair_code_in)))
      else $error("pair selection mismatch");

   // Indirect address is the content of the pair named by the pair code
   AST_INDIRECT: assert property (@(posedge clk_in) disable iff (reset_in) // RULE12
      (clk_en_in && req_valid_in && mode_in == MODE_INDIRECT) |=>
      (mem_sel_out && mem_addr_out ==
         ($past(pair_code_in) == PAIR_AX ? $past(pair_ax_in) :
         $past(pair_code_in) == PAIR_BC ? $past(pair_bc_in) :
         $past(pair_code_in) == PAIR_DE ? $past(pair_de_in) : $past(base_pointer_pair_in))))
      else $error("indirect address mismatch");

   // Offset is the byte read as unsigned, measured up from the base pair
   AST_BASED_OFFSET: assert property (@(posedge clk_in) disable iff (reset_in) // RULE13
      (clk_en_in && req_valid_in && mode_in == MODE_BASED) |=>
      (16'(mem_addr_out - $past(base_pointer_pair_in)) == {8'h00, $past(imm8_in)}))
      else $error("based offset not zero-extended");

   // Stack operations address memory through the stack pointer
   AST_STACK_ADDR: assert property (@(posedge clk_in) disable iff (reset_in) // RULE15
      (clk_en_in && req_valid_in && mode_in == MODE_STACK) |=>
      (mem_addr_out == $past(stack_ptr_in)))
      else $error("stack address mismatch");

   // Even word operands in short mode pass without an error
   AST_EVEN_WORD: assert property (@(posedge clk_in) disable iff (reset_in) // RULE7
      (clk_en_in && req_valid_in && mode_in == MODE_SHORT && word_op_in && !imm8_in[0]) |=>
      (mem_sel_out && !addr_error_out))
      else $error("even word short address refused");

   // Direct mode is a plain memory access with full reach
   AST_DIRECT_SEL: assert property (@(posedge clk_in) disable iff (reset_in) // RULE1
      (clk_en_in && req_valid_in && mode_in == MODE_DIRECT) |=>
      (mem_sel_out && !addr_error_out && !reg_sel_out && !pair_sel_out))
      else $error("direct access not selected as memory");

   // A low enable freezes every result; the consumer may read them late
   AST_FREEZE: assert property (@(posedge clk_in) disable iff (reset_in)
      (!clk_en_in && !reset_in) |=>
      ($stable(addr_valid_out) && $stable(mem_addr_out) && $stable(mem_sel_out) &&
       $stable(addr_error_out) && $stable(reg_num_out) && $stable(pair_num_out)))
      else $error("results moved while enable was low");

   // Valid follows the request by exactly one enabled edge
   AST_VALID_PULSE: assert property (@(posedge clk_in) disable iff (reset_in)
      (clk_en_in && !reset_in) |=>
      (addr_valid_out == $past(req_valid_in)))
      else $error("valid strobe does not follow request");

   // Reset clears the strobe, the address and both flags
   AST_RESET_CLEAR: assert property (@(posedge clk_in)
      reset_in |=>
      (!addr_valid_out && !mem_sel_out && !addr_error_out && mem_addr_out == ADDR_RESET))
      else $error("results not cleared by reset");

   // Register mode selects a byte register and nothing else
   AST_REG_ONLY: assert property (@(posedge clk_in) disable iff (reset_in) // RULE10
      (clk_en_in && req_valid_in && mode_in == MODE_REG) |=>
      (!pair_sel_out && !addr_error_out && mem_addr_out == ADDR_RESET))
      else $error("register mode selected more than a register");

endmodule : operand_address_generator
`default_nettype wire

// File: src/short_map.sv
`timescale 1ns/1ps
`default_nettype none
// Maps 8-bit short operands 00H..1FH and 80H..FFH into the FE80H..FF1FH window
module short_map
   import oper_addr_pkg::*;
(
   // Operand
   input wire logic [7:0] operand_in,
   // Mapped address
   output logic [15:0] address_out
);
   // Operands 00H..1FH reach the special page, the rest page FE (internal RAM only for 80H..FFH)
   always_comb begin
      address_out = {SHORT_UPPER_BITS, (operand_in <= SHORT_SPECIAL_TOP), operand_in}; // RULE4 RULE5 RULE6
   end
endmodule : short_map
`default_nettype wire

// File: verification/operand_address_generator_tb.sv
`timescale 1ns/1ps
`default_nettype none
module operand_address_generator_tb;
   import oper_addr_pkg::*;
   // One expected result per request
   typedef struct {logic en; logic go; logic [15:0] a; logic m; logic e; addr_mode_t md;
      logic [2:0] r; logic [1:0] p;} exp_t;
   logic clk_in = 1'b0, reset_in = 1'b1, clk_en_in = 1'b0, req_valid_in = 1'b0, word_op_in = 1'b0;
   addr_mode_t mode_in = MODE_DIRECT;
   logic [15:0] imm16_in = 16'h0000, word = 16'h0000;
   logic [7:0] imm8_in = 8'h00, i8;
   logic [2:0] reg_code_in = 3'h0, sel = 3'h0;
   logic [1:0] pair_code_in = 2'h0;
   logic load = 1'b0;
   logic [2:0] s3; // Bench-side copy of the load select, set before it is driven
   logic [15:0] w16; // Bench-side copy of the load word
   logic [4:0][15:0] pv;
   logic addr_valid_out, mem_sel_out, reg_sel_out, pair_sel_out, addr_error_out;
   logic [15:0] mem_addr_out;
   logic [2:0] reg_num_out;
   logic [1:0] pair_num_out;
   int mismatches = 0, num_checks = 0, cycles = 0;
   logic [31:0] seed = 32'hAFA774AB, r, h;
   logic [15:0] mir [5] = '{default: 16'h0000}; // Bench copy of the pair contents
   exp_t cur, nxt;
   // Corner operands around the short window split
   logic [7:0] corner [8] = '{8'h00, 8'h1F, 8'h20, 8'h7F, 8'h80, 8'hFE, 8'hFF, 8'h1E};

   pair_source far (.clk_in(clk_in), .reset_in(reset_in), .load_in(load), .sel_in(sel),
      .word_in(word), .val_out(pv));
   operand_address_generator uut (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
      .req_valid_in(req_valid_in), .mode_in(mode_in), .word_op_in(word_op_in),
      .imm16_in(imm16_in), .imm8_in(imm8_in), .reg_code_in(reg_code_in),
      .pair_code_in(pair_code_in), .pair_ax_in(pv[0]), .pair_bc_in(pv[1]), .pair_de_in(pv[2]),
      .base_pointer_pair_in(pv[3]), .stack_ptr_in(pv[4]), .addr_valid_out(addr_valid_out),
      .mem_addr_out(mem_addr_out), .mem_sel_out(mem_sel_out), .reg_sel_out(reg_sel_out),
      .reg_num_out(reg_num_out), .pair_sel_out(pair_sel_out), .pair_num_out(pair_num_out),
      .addr_error_out(addr_error_out));

   // Xorshift source, fixed start so every run repeats
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // Single compare for every result kind, zero-extended to 16 bits
   task automatic check(input string name, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, e, g);
      end
   endtask : check

   task automatic summarize();
      if (mismatches == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize

   initial begin
      forever #50 clk_in = ~clk_in;
   end

   // Hang guard well above the 3000 request cycles
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         mismatches++;
         summarize();
      end
   end

   initial begin
      repeat (8) @(posedge clk_in);
      reset_in <= 1'b0;
      @(negedge clk_in);
      check("reset valid", 16'h0000, 16'(addr_valid_out));
      check("reset addr", 16'h0000, mem_addr_out);
      cur.en = 1'b0;
      repeat (3000) begin
         @(posedge clk_in);
         r = rnd();
         h = rnd();
         i8 = r[8] ? corner[r[11:9]] : r[19:12];
         nxt = '{r[29:27] != 3'h0, r[0] | r[1], 16'h0000, 1'b1, 1'b0, addr_mode_t'(r[7:5]),
            r[23:21], r[25:24]};
         // Stack pointer straddles both RAM edges, base pair often near the top
         s3 = h[18:16];
         w16 = (s3 == 3'h4) ? 16'hFE60 + h[31:24] : {h[19] ? 8'hFF : h[31:24], h[15:8]};
         sel <= s3;
         word <= w16;
         clk_en_in <= nxt.en;
         req_valid_in <= nxt.go;
         mode_in <= nxt.md;
         word_op_in <= r[20];
         imm16_in <= h[15:0];
         imm8_in <= i8;
         reg_code_in <= nxt.r;
         pair_code_in <= nxt.p;
         load <= r[26];
         // Reference model of every addressing mode
         case (nxt.md)
            MODE_DIRECT: nxt.a = h[15:0];
            MODE_SHORT: begin
               // 00H..1FH reach the special registers, every other byte the page below
               nxt.a = (i8 <= 8'h1F) ? {8'hFF, i8} : {8'hFE, i8};
               nxt.e = r[20] & i8[0];
            end
            MODE_SPECIAL: nxt.a = {8'hFF, i8};
            MODE_INDIRECT: nxt.a = mir[nxt.p];
            MODE_BASED: nxt.a = mir[3] + {8'h00, i8};
            MODE_STACK: begin
               nxt.a = mir[4];
               nxt.e = mir[4] < 16'hFE80 || mir[4] > 16'hFEFF;
            end
            default: nxt.m = 1'b0;
         endcase
         nxt.m = nxt.m & ~nxt.e;
         if (r[26] && s3 < 3'h5) begin
            mir[s3] = w16;
         end
         @(negedge clk_in);
         // A frozen cycle holds the previous results, so nothing new to judge
         if (cur.en) begin
            check("valid", 16'(cur.go), 16'(addr_valid_out));
         end
         if (cur.en && cur.go) begin
            check("mem_sel", 16'(cur.m), 16'(mem_sel_out));
            check("error", 16'(cur.e), 16'(addr_error_out));
            if (cur.m || cur.md inside {MODE_REG, MODE_PAIR}) begin
               check("addr", cur.a, mem_addr_out);
            end
            if (cur.md == MODE_REG) begin
               check("reg", 16'({1'b1, cur.r}), 16'({reg_sel_out, reg_num_out}));
            end
            if (cur.md == MODE_PAIR) begin
               check("pair", 16'({1'b1, cur.p}), 16'({pair_sel_out, pair_num_out}));
            end
         end
         cur = nxt;
      end
      summarize();
   end
endmodule : operand_address_generator_tb
`default_nettype wire

// File: verification/pair_source.sv
`timescale 1ns/1ps
`default_nettype none
// Decode-side register file: pairs AX, BC, DE, base pair, then stack pointer
module pair_source (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Load port, select 0..4
   input wire logic load_in,
   input wire logic [2:0] sel_in,
   input wire logic [15:0] word_in,
   // Stored words, index 4 is the stack pointer
   output logic [4:0][15:0] val_out
);
   // Writes land one edge after the strobe, like a real register file
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         val_out <= '0;
      end else if (load_in && sel_in < 3'h5) begin
         val_out[sel_in] <= word_in;
      end
   end
endmodule : pair_source
`default_nettype wire
